// ### design/i2dt_defs.svh
// i2dt_defs.svh: offsets, field positions, reset values and timing counts
// assumes: included by bare name from the package and the register target
`ifndef I2DT_DEFS_SVH
`define I2DT_DEFS_SVH

// register offsets
`define I2DT_CONVERTER_SETUP     8'h00
`define I2DT_FREQ_GAIN_SETUP     8'h01
`define I2DT_CHARGE_HOLD_SETUP   8'h02
`define I2DT_MEASURE_LIMIT_SETUP 8'h03
`define I2DT_EVENT_GATE_LOW      8'h04
`define I2DT_EVENT_GATE_HIGH     8'h05
`define I2DT_PORT_STATE          8'h06
`define I2DT_FAULT_LOG_LOW       8'h07
`define I2DT_FAULT_LOG_HIGH      8'h08
`define I2DT_VOLTAGE_RESULT      8'h09
`define I2DT_CURRENT_RESULT      8'h0a
`define I2DT_LAST_REG            8'h0a

// converter_setup fields
`define I2DT_BUCK_ON_BIT         5
`define I2DT_OUT_LEVEL_HI        4
`define I2DT_OUT_LEVEL_LO        2
`define I2DT_CLK_PIN_DIR_BIT     1
`define I2DT_SPREAD_ON_BIT       0
// measure_limit_setup fields
`define I2DT_MEASURE_GO_BIT      6
`define I2DT_MEASURE_IRQ_EN_BIT  5
`define I2DT_LEVEL_LOCK_BIT      4
// fault_log_high fields
`define I2DT_CONV_COMPLETE_BIT   1
`define I2DT_IN_OV_BIT           0
// port_state fields
`define I2DT_ATTACH_BIT          7
`define I2DT_CFG_OK_BIT          6

// reset values
`define I2DT_CONVERTER_RST       8'h20
`define I2DT_FREQ_GAIN_RST       8'h00
`define I2DT_CHARGE_HOLD_RST     8'h0c
`define I2DT_MEASURE_LIMIT_RST   8'h17
`define I2DT_GATE_RST            8'h00

// voltage full scale in millivolts, per range, over 256 codes
`define I2DT_VFS_LOW_MV          7920
`define I2DT_VFS_HIGH_MV         19800
// current step: 0.1 V / 256 across the shunt, in microvolts times 256
`define I2DT_ISTEP_UV_X256       100000

// timing: clock 100 ns, fastest bus clock 400 kHz (2500 ns period)
`define I2DT_CLK_NS              100
`define I2DT_SCL_MIN_NS          2500
`define I2DT_SPIKE_NS            50
`define I2DT_FILT_CYC            ((`I2DT_SPIKE_NS + `I2DT_CLK_NS - 1) / `I2DT_CLK_NS + 1)
`define I2DT_SCL_CYC             (`I2DT_SCL_MIN_NS / `I2DT_CLK_NS)

`endif

// ### design/i2dt_pkg.sv
// i2dt_pkg: types of the diagnostic register target
// assumes: i2dt_defs.svh on the include path
`include "i2dt_defs.svh"

package i2dt_pkg;

    // gray codes along idle -> receive -> ack -> send -> master ack
    typedef enum logic [2:0]
    {
        I2DT_IDLE   = 3'h0,
        I2DT_RX     = 3'h1,
        I2DT_RX_ACK = 3'h3,
        I2DT_TX     = 3'h2,
        I2DT_TX_ACK = 3'h6
    } i2dt_state_e;

    typedef logic [7:0] i2dt_byte_t;

endpackage

// ### design/i2dt_target.sv
// i2dt_target: two-wire register target with fault log, event line and
// measurement sequencing for a buck converter / port power controller.
// assumes: scl, sda and the variant strap arrive from pins (synchronised here);
// fault levels and the converter handshake come from logic on clock.
//
// Behaviour
// - open-drain low output is event line; on stand-alone variant it shows presence
// - fault pin follows live faults, untouched by any register setting
// - event gates only decide whether set log bits pull event low
// - writing measure_go starts measurement; completion clears it, sets conv_complete
// - with measure_irq_en set, measurement completion asserts the event line
// - voltage result at 0x09, current result at 0x0a, both read-only
// - voltage range 7.92V when out_level_sel zero, else 19.8V, 256 codes
// - current code step is 0.1/256 volts across the shunt
// - master makes scl and starts transfers; works up to 400kHz
// - eight-bit bytes each followed by an ack pulse; address first
// - scl input only; sda open-drain output and also sampled
// - short spikes on scl and sda are filtered out
// - one bit per scl cycle; sda change while scl high is a condition
// - sda fall with scl high is start; rise is stop, freeing bus
// - repeated start keeps bus and begins a new transfer
// - stop taken anywhere, except in the same scl high as a start
// - never holds scl low
// - general call address is not acknowledged
// - buck_on zero disables regulator, one enables; resets to one
// - out_level_sel 000 5V, 001 18V, 010 9V, 011 12V, rest reserved
// - clk_pin_dir zero makes sync pin output, one input
// - spread_on zero disables spread spectrum, one enables
// - reading a fault log clears it; live faults set again at once
// - reading the log releases event; persisting enabled fault drives again
// - gate bit one lets matching log bit assert event, zero blocks
`timescale 1ns/1ps
`default_nettype none
`include "i2dt_defs.svh"

module i2dt_target
    import i2dt_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR      = 7'h2a,
    parameter int         FILT_CYC      = `I2DT_FILT_CYC,
    parameter logic [1:0] CLK_SPREAD_RST = 2'h0,
    parameter logic [1:0] CHARGE_RST    = 2'h0
)
(
    input  wire logic       clock,
    input  wire logic       rst_b,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe,
    input  wire logic       bus_variant_i,
    input  wire logic [8:0] fault_live,
    input  wire logic       attach_live,
    input  wire logic       cfg_ok_live,
    output logic            event_o,
    output logic            event_oe,
    output logic            fault_o,
    output logic            fault_oe,
    output logic            meas_start,
    output logic            meas_range_high,
    input  wire logic       meas_done,
    input  wire logic [7:0] meas_volt,
    input  wire logic [7:0] meas_curr,
    output logic            buck_on,
    output logic [2:0]      out_level_sel,
    output logic            clk_pin_dir,
    output logic            spread_on,
    output logic [7:0]      freq_gain,
    output logic [7:0]      charge_hold,
    output logic [7:0]      measure_limit
);

    if (DEV_ADDR == 7'h00 || FILT_CYC < 2 || FILT_CYC > 8)
    begin
        $error("i2dt_target: unusable parameter");
    end

    // reset release
    logic [1:0] rst_sync_r;
    logic       rst_n;

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            rst_sync_r <= 2'h0;
        else
            rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
    assign rst_n = rst_sync_r[1];

    // pin synchronisers: first stage read only by the second
    logic [2:0] pin_s1_r;
    logic [2:0] pin_s2_r;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_s1_r <= 3'h7;
            pin_s2_r <= 3'h7;
        end
        else
        begin
            pin_s1_r <= {bus_variant_i, sda_i, scl_i};
            pin_s2_r <= pin_s1_r;
        end
    end

    // strap caught once after release
    logic       bus_variant_r;
    logic [1:0] strap_cnt_r;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bus_variant_r <= 1'b1;
            strap_cnt_r   <= 2'h0;
        end
        else if (strap_cnt_r != 2'h3)
        begin
            bus_variant_r <= pin_s2_r[2];
            strap_cnt_r   <= strap_cnt_r + 2'h1;
        end
    end

    // spike filter
    // a level must stand FILT_CYC samples; costs a few cycles of latency
    logic [7:0] filt_hist_r [2];
    logic [1:0] line_r;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            filt_hist_r[0] <= 8'hff;
            filt_hist_r[1] <= 8'hff;
            line_r         <= 2'h3;
        end
        else
        begin
            for (int k = 0; k < 2; k++)
            begin
                filt_hist_r[k] <= {filt_hist_r[k][6:0], pin_s2_r[k]};
                if (&filt_hist_r[k][FILT_CYC-1:0])
                    line_r[k] <= 1'b1;
                else if (~|filt_hist_r[k][FILT_CYC-1:0])
                    line_r[k] <= 1'b0;
            end
        end
    end

    // bus conditions
    logic [1:0] line_d_r;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_det;
    logic       stop_raw;
    logic       stop_det;
    logic       start_in_high_r;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            line_d_r <= 2'h3;
        else
            line_d_r <= line_r;
    end

    assign scl_rise = line_r[0] & ~line_d_r[0];
    assign scl_fall = ~line_r[0] & line_d_r[0];
    assign start_det = line_r[0] & line_d_r[0] & ~line_r[1] & line_d_r[1];
    assign stop_raw  = line_r[0] & line_d_r[0] & line_r[1] & ~line_d_r[1];
    // stop refused in start's high pulse
    assign stop_det  = stop_raw & ~start_in_high_r;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            start_in_high_r <= 1'b0;
        else if (start_det)
            start_in_high_r <= 1'b1;
        else if (scl_fall)
            start_in_high_r <= 1'b0;
    end

    // registers
    logic [7:0] conv_r;
    logic [7:0] freq_r;
    logic [7:0] hold_r;
    logic [7:0] meas_r;
    logic [7:0] gate_lo_r;
    logic [7:0] gate_hi_r;
    logic [7:0] log_lo_r;
    logic [7:0] log_hi_r;
    logic [7:0] volt_r;
    logic [7:0] curr_r;

    // transfer state
    i2dt_state_e state_r;
    logic [3:0]  bit_cnt_r;
    logic [7:0]  shift_r;
    logic [7:0]  ptr_r;
    logic [1:0]  byte_idx_r;
    logic        reading_r;
    logic        wr_stb;
    logic        rd_stb;
    logic        addr_hit;

    function automatic logic [7:0] reg_read(input logic [7:0] a);
        case (a)
            `I2DT_CONVERTER_SETUP:     reg_read = conv_r;
            `I2DT_FREQ_GAIN_SETUP:     reg_read = freq_r;
            `I2DT_CHARGE_HOLD_SETUP:   reg_read = hold_r;
            `I2DT_MEASURE_LIMIT_SETUP: reg_read = meas_r;
            `I2DT_EVENT_GATE_LOW:      reg_read = gate_lo_r;
            `I2DT_EVENT_GATE_HIGH:     reg_read = gate_hi_r;
            `I2DT_PORT_STATE:          reg_read = {attach_live, cfg_ok_live, 6'h00};
            `I2DT_FAULT_LOG_LOW:       reg_read = log_lo_r;
            `I2DT_FAULT_LOG_HIGH:      reg_read = log_hi_r;
            `I2DT_VOLTAGE_RESULT:      reg_read = volt_r;
            `I2DT_CURRENT_RESULT:      reg_read = curr_r;
            default:                   reg_read = 8'h00;
        endcase
    endfunction

    assign addr_hit = (shift_r[7:1] == DEV_ADDR) && (shift_r[7:1] != 7'h00);
    assign wr_stb   = (state_r == I2DT_RX) && scl_fall && (bit_cnt_r == 4'h8)
                      && (byte_idx_r == 2'h2);
    assign rd_stb   = scl_fall && reading_r && ((state_r == I2DT_RX_ACK)
                      || ((state_r == I2DT_TX_ACK) && !line_r[1]));

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r    <= I2DT_IDLE;
            bit_cnt_r  <= 4'h0;
            shift_r    <= 8'h00;
            byte_idx_r <= 2'h0;
            reading_r  <= 1'b0;
            sda_oe     <= 1'b0;
        end
        else if (start_det)
        begin
            state_r    <= I2DT_RX;
            bit_cnt_r  <= 4'h0;
            byte_idx_r <= 2'h0;
            reading_r  <= 1'b0;
            sda_oe     <= 1'b0;
        end
        else if (stop_det)
        begin
            state_r <= I2DT_IDLE;
            sda_oe  <= 1'b0;
        end
        else
        begin
            unique case (state_r)
                I2DT_IDLE:
                begin
                    sda_oe <= 1'b0;
                end
                I2DT_RX:
                begin
                    if (scl_rise)
                    begin
                        shift_r   <= {shift_r[6:0], line_r[1]};
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                    end
                    else if (scl_fall && bit_cnt_r == 4'h8)
                    begin
                        bit_cnt_r <= 4'h0;
                        if (byte_idx_r != 2'h0 || addr_hit)
                        begin
                            state_r <= I2DT_RX_ACK;
                            sda_oe  <= 1'b1;
                            if (byte_idx_r == 2'h0)
                                reading_r <= shift_r[0];
                        end
                        else
                        begin
                            state_r <= I2DT_IDLE;
                        end
                    end
                end
                I2DT_RX_ACK:
                begin
                    if (scl_fall)
                    begin
                        if (byte_idx_r != 2'h2)
                            byte_idx_r <= byte_idx_r + 2'h1;
                        if (reading_r)
                        begin
                            state_r <= I2DT_TX;
                            shift_r <= reg_read(ptr_r);
                            sda_oe  <= reg_read(ptr_r) < 8'h80;
                        end
                        else
                        begin
                            state_r <= I2DT_RX;
                            sda_oe  <= 1'b0;
                        end
                    end
                end
                I2DT_TX:
                begin
                    if (scl_fall)
                    begin
                        if (bit_cnt_r == 4'h7)
                        begin
                            bit_cnt_r <= 4'h0;
                            state_r   <= I2DT_TX_ACK;
                            sda_oe    <= 1'b0;
                        end
                        else
                        begin
                            bit_cnt_r <= bit_cnt_r + 4'h1;
                            shift_r   <= {shift_r[6:0], 1'b0};
                            sda_oe    <= ~shift_r[6];
                        end
                    end
                end
                I2DT_TX_ACK:
                begin
                    // master nack leaves the target silent until a condition
                    if (scl_fall)
                    begin
                        if (!line_r[1])
                        begin
                            state_r <= I2DT_TX;
                            shift_r <= reg_read(ptr_r);
                            sda_oe  <= reg_read(ptr_r) < 8'h80;
                        end
                        else
                        begin
                            state_r <= I2DT_IDLE;
                        end
                    end
                end
                default:
                begin
                    state_r <= I2DT_IDLE;
                    sda_oe  <= 1'b0;
                end
            endcase
        end
    end

    assign sda_o = 1'b0;

    // pointer: set by first data byte, steps after each data byte
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            ptr_r <= 8'h00;
        else if (state_r == I2DT_RX && scl_fall && bit_cnt_r == 4'h8 && byte_idx_r == 2'h1)
            ptr_r <= shift_r;
        else if (wr_stb || rd_stb)
            ptr_r <= ptr_r + 8'h01;
    end

    // setup registers
    // buck_on resets to one
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            conv_r    <= `I2DT_CONVERTER_RST | {6'h00, CLK_SPREAD_RST};
            freq_r    <= `I2DT_FREQ_GAIN_RST;
            hold_r    <= `I2DT_CHARGE_HOLD_RST | {CHARGE_RST, 6'h00};
            gate_lo_r <= `I2DT_GATE_RST;
            gate_hi_r <= `I2DT_GATE_RST;
        end
        else if (wr_stb)
        begin
            case (ptr_r)
                `I2DT_CONVERTER_SETUP:
                begin
                    conv_r <= shift_r;
                    // level field frozen while the lock bit is set
                    if (meas_r[`I2DT_LEVEL_LOCK_BIT])
                        conv_r[`I2DT_OUT_LEVEL_HI:`I2DT_OUT_LEVEL_LO] <= out_level_sel;
                end
                `I2DT_FREQ_GAIN_SETUP:   freq_r    <= shift_r;
                `I2DT_CHARGE_HOLD_SETUP: hold_r    <= shift_r;
                `I2DT_EVENT_GATE_LOW:    gate_lo_r <= shift_r;
                `I2DT_EVENT_GATE_HIGH:   gate_hi_r <= {7'h00, shift_r[0]};
                default:                 ;
            endcase
        end
    end

    logic meas_busy_r;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meas_r      <= `I2DT_MEASURE_LIMIT_RST;
            meas_busy_r <= 1'b0;
            meas_start  <= 1'b0;
        end
        else
        begin
            meas_start <= 1'b0;
            if (wr_stb && ptr_r == `I2DT_MEASURE_LIMIT_SETUP)
                meas_r <= shift_r;
            if (meas_busy_r && meas_done)
            begin
                meas_busy_r <= 1'b0;
                meas_r[`I2DT_MEASURE_GO_BIT] <= 1'b0;
            end
            else if (!meas_busy_r && meas_r[`I2DT_MEASURE_GO_BIT])
            begin
                meas_busy_r <= 1'b1;
                meas_start  <= 1'b1;
            end
        end
    end

    // current code passed as converted, 0.1/256 V per step
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            volt_r <= 8'h00;
            curr_r <= 8'h00;
        end
        else if (meas_busy_r && meas_done)
        begin
            volt_r <= meas_volt;
            curr_r <= meas_curr;
        end
    end

    assign meas_range_high = (out_level_sel != 3'h0);

    // clear on read, set wins over clear
    logic clr_lo;
    logic clr_hi;
    logic done_set;

    assign clr_lo   = rd_stb && ptr_r == `I2DT_FAULT_LOG_LOW;
    assign clr_hi   = rd_stb && ptr_r == `I2DT_FAULT_LOG_HIGH;
    assign done_set = meas_busy_r && meas_done;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            log_lo_r <= 8'h00;
            log_hi_r <= 8'h00;
        end
        else
        begin
            log_lo_r <= (clr_lo ? 8'h00 : log_lo_r) | fault_live[7:0];
            log_hi_r <= (clr_hi ? 8'h00 : log_hi_r)
                        | {6'h00, done_set, fault_live[8]};
        end
    end

    // gates only steer the event line
    logic event_req;

    assign event_req = |(log_lo_r & gate_lo_r)
                       | (log_hi_r[`I2DT_IN_OV_BIT] & gate_hi_r[0])
                       | (log_hi_r[`I2DT_CONV_COMPLETE_BIT]
                          & meas_r[`I2DT_MEASURE_IRQ_EN_BIT]);

    // event line or presence line by variant
    // released by the clearing read, redriven by live faults
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            event_oe <= 1'b0;
        else if (bus_variant_r)
            event_oe <= event_req;
        else
            event_oe <= attach_live;
    end
    assign event_o = 1'b0;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            fault_oe <= 1'b0;
        else
            fault_oe <= |fault_live;
    end
    assign fault_o = 1'b0;

    // filter plus edge logic fits a 25-cycle bus clock
    assign buck_on       = conv_r[`I2DT_BUCK_ON_BIT];
    assign out_level_sel = conv_r[`I2DT_OUT_LEVEL_HI:`I2DT_OUT_LEVEL_LO];
    assign clk_pin_dir   = conv_r[`I2DT_CLK_PIN_DIR_BIT];
    assign spread_on     = conv_r[`I2DT_SPREAD_ON_BIT];
    assign freq_gain     = freq_r;
    assign charge_hold   = hold_r;
    assign measure_limit = meas_r;

endmodule

`default_nettype wire

// ### tb/i2dt_target_checker.sv
// i2dt_target_checker: port-level assertions for the register target
// assumes: bound to i2dt_target, single clock domain
`timescale 1ns/1ps
`default_nettype none
module i2dt_target_checker
(
    input wire logic       clock,
    input wire logic       rst_b,
    input wire logic       scl_i,
    input wire logic       sda_o,
    input wire logic       sda_oe,
    input wire logic       event_o,
    input wire logic       event_oe,
    input wire logic       fault_oe,
    input wire logic [8:0] fault_live,
    input wire logic       meas_start,
    input wire logic       meas_range_high,
    input wire logic [2:0] out_level_sel,
    input wire logic       buck_on
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    a_sda_open_drain: assert property (sda_o == 1'b0)
        else $error("sda driven high");
    a_event_open_drain: assert property (event_o == 1'b0)
        else $error("event line driven high");
    a_fault_pin_set: assert property ((|fault_live) |=> fault_oe)
        else $error("fault pin missed a live fault");
    a_fault_pin_clear: assert property (!(|fault_live) |=> !fault_oe)
        else $error("fault pin without live fault");
    a_meas_one_pulse: assert property (meas_start |=> !meas_start)
        else $error("measure start longer than one cycle");
    a_range_select: assert property ($stable(out_level_sel) ##1 $stable(out_level_sel)
        |-> meas_range_high == (out_level_sel != 3'h0))
        else $error("range does not follow output level");
    a_buck_reset: assert property (disable iff (1'b0) !rst_b [*3]
        |-> buck_on && out_level_sel == 3'h0)
        else $error("converter setup not at reset value");
    // sda moves only while scl is low
    a_sda_low_phase: assert property ($changed(sda_oe) |-> !scl_i)
        else $error("sda moved while scl high");
    c_measure: cover property (meas_start);
    c_ack: cover property ($rose(sda_oe));
    c_event: cover property ($rose(event_oe));
endmodule

bind i2dt_target i2dt_target_checker i_chk
(
    .clock(clock), .rst_b(rst_b), .scl_i(scl_i), .sda_o(sda_o), .sda_oe(sda_oe),
    .event_o(event_o), .event_oe(event_oe), .fault_oe(fault_oe), .fault_live(fault_live),
    .meas_start(meas_start), .meas_range_high(meas_range_high),
    .out_level_sel(out_level_sel), .buck_on(buck_on)
);
`default_nettype wire

// ### tb/i2dt_bus_master.sv
// i2dt_bus_master: behavioural two-wire bus master facing the target
// assumes: pull-up resolved in tb; moves only on clock edges, scl idles high
`timescale 1ns/1ps
`default_nettype none
module i2dt_bus_master
    import i2dt_pkg::*;
#(
    parameter logic [6:0] DEV = 7'h2a,
    parameter int         Q   = 7
)
(
    input  wire logic clock,
    input  wire logic sda,
    output logic      scl = 1'b1,
    output logic      sda_pull = 1'b0
);
    // quarter of 7 cycles keeps scl under 400kHz
    task automatic w();
        repeat (Q) @(posedge clock);
    endtask
    // sda moves with scl high: start or repeated start, or stop
    task automatic cond(input logic a, input logic b);
        w();
        sda_pull <= a;
        w();
        scl <= 1'b1;
        w();
        sda_pull <= b;
        if (b)
        begin
            w();
            scl <= 1'b0;
        end
    endtask
    // eight bits msb first plus ack clock, sda changed with scl low
    task automatic xfer(input i2dt_byte_t d, input logic rel, output i2dt_byte_t r,
                        output logic ack);
        logic [8:0] s;
        for (int i = 8; i >= 0; i--)
        begin
            w();
            sda_pull <= ~(i == 0 ? rel : d[i - 1]);
            w();
            scl <= 1'b1;
            w();
            w();
            s[i] = sda;
            scl <= 1'b0;
        end
        r = s[8:1];
        ack = ~s[0];
    endtask
    // register write: start, address, pointer byte, data byte, then stop
    task automatic wr(input i2dt_byte_t a, input i2dt_byte_t d, output logic ok);
        i2dt_byte_t r;
        logic       k0, k1, k2;
        cond(1'b0, 1'b1);
        xfer({DEV, 1'b0}, 1'b1, r, k0);
        xfer(a, 1'b1, r, k1);
        xfer(d, 1'b1, r, k2);
        cond(1'b1, 1'b0);
        ok = k0 & k1 & k2;
    endtask
    task automatic rd(input i2dt_byte_t a, input int n, output i2dt_byte_t v [11]);
        logic k;
        cond(1'b0, 1'b1);
        xfer({DEV, 1'b0}, 1'b1, v[0], k);
        xfer(a, 1'b1, v[0], k);
        cond(1'b0, 1'b1);
        xfer({DEV, 1'b1}, 1'b1, v[0], k);
        for (int i = 0; i < n; i++)
            xfer(8'hff, i == n - 1, v[i], k);
        cond(1'b1, 1'b0);
    endtask
    // address byte then an early stop
    task automatic probe(input i2dt_byte_t b, output logic k);
        i2dt_byte_t r;
        cond(1'b0, 1'b1);
        xfer(b, 1'b1, r, k);
        cond(1'b1, 1'b0);
    endtask
endmodule
`default_nettype wire

// ### tb/tb.sv
// tb: register target bench, master model on the bus, converter driven here
// assumes: pull-up on sda; scl only ever driven by the master
`timescale 1ns/1ps
`default_nettype none
`include "i2dt_defs.svh"
module tb;
    import i2dt_pkg::*;
    localparam logic [6:0] DEV = 7'h2a;
    localparam i2dt_byte_t RST [11] = '{`I2DT_CONVERTER_RST, 8'h00, `I2DT_CHARGE_HOLD_RST,
        8'h17, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic       clock = 1'b0, rst_b = 1'b0, meas_done = 1'b0, ok;
    logic       scl, m_pull, sda_o, sda_oe, event_o, event_oe, fault_o, fault_oe;
    logic       meas_start, range_hi, buck_on, pin_dir, spread_on;
    logic [2:0] level;
    logic [7:0] volt = 8'h00, curr = 8'h00, gain, hold, limit;
    logic [8:0] fault_live = 9'h000;
    i2dt_byte_t v [11];
    int         failures = 0, check_count = 0, starts = 0;
    wire logic  sda = ~(sda_oe | m_pull);
    i2dt_target #(.DEV_ADDR(DEV)) i_dut
    (
        .clock(clock), .rst_b(rst_b), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe(sda_oe), .bus_variant_i(1'b1), .fault_live(fault_live), .attach_live(1'b0),
        .cfg_ok_live(1'b0), .event_o(event_o), .event_oe(event_oe), .fault_o(fault_o),
        .fault_oe(fault_oe), .meas_start(meas_start), .meas_range_high(range_hi),
        .meas_done(meas_done), .meas_volt(volt), .meas_curr(curr), .buck_on(buck_on),
        .out_level_sel(level), .clk_pin_dir(pin_dir), .spread_on(spread_on),
        .freq_gain(gain), .charge_hold(hold), .measure_limit(limit)
    );
    i2dt_bus_master #(.DEV(DEV)) i_master
    (
        .clock(clock), .sda(sda), .scl(scl), .sda_pull(m_pull)
    );
    initial
    begin
        forever #50 clock = ~clock;
    end
    always @(posedge clock)
        if (meas_start === 1'b1)
            starts <= starts + 1;
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        repeat (20) @(posedge clock);
        rst_b <= 1'b1;
        repeat (25) @(posedge clock);
        i_master.rd(8'h00, 11, v);
        for (int i = 0; i < 11; i++)
            check("reset value", v[i], RST[i]);
        check("setups", hold ^ gain, 8'h0c);
        i_master.probe(8'h00, ok);
        check("general call ack", {7'h0, ok}, 8'h00);
        i_master.probe({~DEV, 1'b0}, ok);
        check("foreign address ack", {7'h0, ok}, 8'h00);
        // unlock level first
        i_master.wr(8'h03, 8'h07, ok);
        for (int i = 0; i < 4; i++)
        begin
            i_master.wr(8'h00, {2'b00, i[0], i[2:0], i[1], i[0]}, ok);
            check("write ack", {7'h0, ok}, 8'h01);
            check("setup fields", {1'b0, buck_on, level, pin_dir, spread_on, range_hi},
                  {1'b0, i[0], i[2:0], i[1], i[0], i != 0});
        end
        i_master.wr(8'h09, 8'h5a, ok);
        i_master.rd(8'h09, 1, v);
        check("read-only result", v[0], 8'h00);
        volt <= 8'hc3;
        curr <= 8'h3c;
        i_master.wr(8'h03, 8'h67, ok);
        check("start pulses", starts[7:0], 8'h01);
        meas_done <= 1'b1;
        @(posedge clock);
        meas_done <= 1'b0;
        repeat (3) @(posedge clock);
        check("event on done", {7'h0, event_oe}, 8'h01);
        i_master.rd(8'h03, 1, v);
        check("go cleared", v[0], 8'h27);
        check("limit", limit, 8'h27);
        i_master.rd(8'h08, 3, v);
        check("done flag", v[0], 8'h02);
        check("voltage", v[1], 8'hc3);
        check("current", v[2], 8'h3c);
        check("event released", {7'h0, event_oe}, 8'h00);
        fault_live <= 9'h008;
        repeat (4) @(posedge clock);
        check("fault pin gate shut", {6'h0, fault_oe, event_oe}, 8'h02);
        i_master.wr(8'h04, 8'h08, ok);
        check("gated event", {7'h0, event_oe}, 8'h01);
        i_master.rd(8'h07, 1, v);
        check("log read", v[0], 8'h08);
        fault_live <= 9'h000;
        repeat (4) @(posedge clock);
        check("event persists", {6'h0, fault_oe, event_oe}, 8'h01);
        i_master.rd(8'h07, 2, v);
        check("log latched", v[0], 8'h08);
        check("done cleared", v[1], 8'h00);
        check("event off", {7'h0, event_oe}, 8'h00);
        give_verdict();
    end
endmodule
`default_nettype wire
